// ---- verilog/acsw_top.sv ----
// Purpose: command packet receiver, opcode decoder, busy and failsafe watchdog
// Assumes: link bytes and events arrive as one-cycle strobes on link_clk_i, bytes
//          at least 4 system cycles apart
// Notes: command execution itself sits outside; exec_done_i ends the busy phase
`timescale 1ns/1ps
`include "acsw_defs.svh"
// Behaviour
// [R1] watchdog starts when a valid wake token is accepted
// [R2] watchdog expiry forces sleep, abandoning transfer or execution
// [R3] watchdog restarts only via sleep or idle followed by wake
// [R4] entering sleep clears scratch SRAM and all status
// [R5] idle keeps scratch key register and random seed
// [R6] host finishes SRAM-dependent sequences within one failsafe interval
// [R7] byte 0 is the type flag, outside count and CRC
// [R8] byte 1 is length covering count through CRC, not the flag
// [R9] opcode, first parameter, two-byte second parameter, then optional data
// [R10] last two bytes are CRC-16 poly 0x8005 over count through data
// [R11] after the last byte the device turns busy and runs the command
// [R12] while busy every link transition is ignored
// [R13] single-wire incomplete packet sleeps after the incomplete-frame interval
// [R14] I2C incomplete packet waits for watchdog or start/stop
// [R15] wrong length reaction is per command, error not always reported
// [R16] decode 0x1C key derivation, 0x30 revision, 0x15 digest
// [R17] decode 0x11 HMAC, 0x28 MAC verify, 0x17 zone lock
// [R18] decode 0x08 MAC, 0x16 nonce, 0x01 selective idle
// [R19] decode 0x1B random, 0x02 read, 0x47 SHA-256
// [R20] 0x20 updates only bytes 84 or 85, only once config is locked
// [R21] 0x12 writes 4 or 32 bytes
// [R22] execution bounded by the documented maximum
// [R23] host waits typical execution time before polling
// [R24] after wake the status block holds 0x11
// [R25] CRC or link fault gives 0xFF with no parse or execution
// [R26] host enters idle over I2C by address, 0x02, stop
// [R27] failsafe interval is a parameterised cycle count
// [R28] unknown opcode reports parse failure
module acsw_top #(
    parameter int unsigned FAILSAFE_CYCLES = `ACSW_FAILSAFE_CYC,
    parameter int unsigned TIMEOUT_CYCLES = `ACSW_TIMEOUT_CYC,
    parameter int unsigned EXEC_MAX_CYCLES = `ACSW_EXEC_MAX_CYC
) (
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire logic link_clk_i,
    input wire logic link_byte_vld_i,
    input wire logic [7:0] link_byte_i,
    input wire logic link_wake_i,
    input wire logic link_stsp_i,
    input wire logic link_idle_i,
    input wire logic link_sleep_i,
    input wire logic single_wire_i,
    input wire logic config_locked_i,
    input wire logic exec_done_i,
    input wire logic [7:0] exec_status_i,
    output logic link_busy_o,
    output logic awake_o,
    output logic busy_o,
    output logic idle_o,
    output logic sram_clear_o,
    output logic [7:0] status_o,
    output logic cmd_start_o,
    output logic exec_abort_o,
    output logic [7:0] cmd_opcode_o,
    output acsw_pkg::acsw_kind_t cmd_kind_o,
    output logic [7:0] cmd_p1_o,
    output logic [15:0] cmd_p2_o,
    output logic data_vld_o,
    output logic [7:0] data_o
);
    if (FAILSAFE_CYCLES < 2 || TIMEOUT_CYCLES < 2 || EXEC_MAX_CYCLES < 2) begin : g_chk
        $error("acsw_top: counts must be at least 2");
    end

    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c;
        for (int i = 7; i >= 0; i--) begin
            r = (r[15] ^ b[i]) ? ((r << 1) ^ `ACSW_CRC_POLY) : (r << 1);
        end
        return r;
    endfunction : crc_byte

    function automatic acsw_pkg::acsw_kind_t decode(input logic [7:0] op);
        case (op)
            `ACSW_OP_KEYDER: return acsw_pkg::K_KEYDER; // [R16]
            `ACSW_OP_REV: return acsw_pkg::K_REV; // [R16]
            `ACSW_OP_DIGEST: return acsw_pkg::K_DIGEST; // [R16]
            `ACSW_OP_HMAC: return acsw_pkg::K_HMAC; // [R17]
            `ACSW_OP_CHKMAC: return acsw_pkg::K_CHKMAC; // [R17]
            `ACSW_OP_LOCK: return acsw_pkg::K_LOCK; // [R17]
            `ACSW_OP_MAC: return acsw_pkg::K_MAC; // [R18]
            `ACSW_OP_NONCE: return acsw_pkg::K_NONCE; // [R18]
            `ACSW_OP_PAUSE: return acsw_pkg::K_PAUSE; // [R18]
            `ACSW_OP_RAND: return acsw_pkg::K_RAND; // [R19]
            `ACSW_OP_READ: return acsw_pkg::K_READ; // [R19]
            `ACSW_OP_SHA: return acsw_pkg::K_SHA; // [R19]
            `ACSW_OP_EXTRA: return acsw_pkg::K_EXTRA; // [R20]
            `ACSW_OP_WRITE: return acsw_pkg::K_WRITE; // [R21]
            default: return acsw_pkg::K_NONE;
        endcase
    endfunction : decode

    // link domain: events become toggles, bytes a held word plus a toggle
    logic [`ACSW_EV_N-1:0] ltog_r;
    logic [7:0] lbyte_r;
    logic [1:0] lbusy_sync_r;
    logic busy_r;
    wire l_busy = lbusy_sync_r[1];
    wire l_take = link_byte_vld_i & ~l_busy; // [R12]
    wire [`ACSW_EV_N-1:0] l_ev = {l_take, link_sleep_i & ~l_busy, link_idle_i & ~l_busy,
                                  link_stsp_i & ~l_busy, link_wake_i & ~l_busy}; // [R12]

    always_ff @(posedge link_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ltog_r <= '0;
            lbyte_r <= 8'h00;
            lbusy_sync_r <= 2'b00;
        end else begin
            ltog_r <= ltog_r ^ l_ev;
            lbusy_sync_r <= {lbusy_sync_r[0], busy_r};
            if (l_take) begin
                lbyte_r <= link_byte_i;
            end
        end
    end
    assign link_busy_o = l_busy;

    // system domain crossing
    logic [`ACSW_EV_N-1:0] s1_r, s2_r, s3_r;
    logic [1:0] swi_sync_r;
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            swi_sync_r <= 2'b00;
        end else begin
            s1_r <= ltog_r;
            s2_r <= s1_r;
            s3_r <= s2_r;
            swi_sync_r <= {swi_sync_r[0], single_wire_i};
        end
    end
    wire [`ACSW_EV_N-1:0] ev = s2_r ^ s3_r;
    wire ev_wake = ev[`ACSW_EV_WAKE];
    wire ev_stsp = ev[`ACSW_EV_STSP];
    wire ev_idle = ev[`ACSW_EV_IDLE];
    wire ev_sleep = ev[`ACSW_EV_SLEEP];
    wire ev_byte = ev[`ACSW_EV_BYTE];
    wire swi_mode = swi_sync_r[1];

    acsw_pkg::acsw_state_t st_r, st_nxt;
    logic [31:0] wdog_r, tmo_r, exec_r;
    logic [7:0] idx_r, cnt_r, op_r, p1_r, crc_lo_r, status_r;
    logic [15:0] p2_r, crc_r;
    logic have_flag_r, running_r, sram_clr_r, start_r, abort_r, dvld_r;
    logic [7:0] data_r;

    wire awake = (st_r == acsw_pkg::ST_AWAKE) | (st_r == acsw_pkg::ST_RX) |
                 (st_r == acsw_pkg::ST_BUSY);
    wire wdog_exp = awake & (wdog_r >= FAILSAFE_CYCLES - 1); // [R2] [R27]
    wire tmo_exp = (st_r == acsw_pkg::ST_RX) & swi_mode &
                   (tmo_r >= TIMEOUT_CYCLES - 1); // [R13]
    wire exec_exp = running_r & (exec_r >= EXEC_MAX_CYCLES - 1); // [R22]
    wire last_byte = (st_r == acsw_pkg::ST_RX) & ev_byte & have_flag_r &
                     (idx_r == cnt_r - 8'h01) & (idx_r != `ACSW_POS_COUNT); // [R8] [R11]
    wire in_crc = (idx_r >= cnt_r - 8'h02); // [R10]
    // the byte word is held until the next strobe, so reading it on the event is safe
    wire [7:0] s_byte = lbyte_r;
    wire crc_ok = ({s_byte, crc_lo_r} == crc_r) & (cnt_r >= `ACSW_MIN_COUNT); // [R10]
    wire acsw_pkg::acsw_kind_t kind = decode(op_r);
    wire [7:0] dlen = cnt_r - `ACSW_MIN_COUNT;
    wire bad_extra = (kind == acsw_pkg::K_EXTRA) & (~config_locked_i |
                     ((p2_r[7:0] != `ACSW_EXTRA_LO) & (p2_r[7:0] != `ACSW_EXTRA_HI))); // [R20]
    wire bad_write = (kind == acsw_pkg::K_WRITE) &
                     (dlen != `ACSW_WR_SHORT) & (dlen != `ACSW_WR_LONG); // [R21] [R15]
    wire parse_bad = (kind == acsw_pkg::K_NONE) | bad_write; // [R28]

    always_comb begin
        st_nxt = st_r;
        case (st_r)
            acsw_pkg::ST_SLEEP: if (ev_wake) st_nxt = acsw_pkg::ST_AWAKE; // [R1]
            acsw_pkg::ST_IDLE: begin
                if (ev_wake) st_nxt = acsw_pkg::ST_AWAKE; // [R3]
                else if (ev_sleep) st_nxt = acsw_pkg::ST_SLEEP;
            end
            acsw_pkg::ST_AWAKE: begin
                if (ev_sleep) st_nxt = acsw_pkg::ST_SLEEP;
                else if (ev_idle) st_nxt = acsw_pkg::ST_IDLE;
                else if (ev_byte) st_nxt = acsw_pkg::ST_RX; // [R7]
            end
            acsw_pkg::ST_RX: begin
                if (tmo_exp) st_nxt = acsw_pkg::ST_SLEEP; // [R13]
                else if (ev_stsp & ~swi_mode) st_nxt = acsw_pkg::ST_AWAKE; // [R14]
                else if (last_byte) st_nxt = acsw_pkg::ST_BUSY; // [R11]
            end
            acsw_pkg::ST_BUSY: begin
                if (!running_r && !start_r) st_nxt = acsw_pkg::ST_AWAKE;
                else if (running_r && (exec_done_i || exec_exp)) st_nxt = acsw_pkg::ST_AWAKE;
            end
            default: st_nxt = acsw_pkg::ST_SLEEP;
        endcase
        if (wdog_exp) st_nxt = acsw_pkg::ST_SLEEP; // [R2]
    end

    wire to_sleep = (st_nxt == acsw_pkg::ST_SLEEP) & (st_r != acsw_pkg::ST_SLEEP);
    wire decide = last_byte & ~wdog_exp;
    wire awake_entry = (st_r == acsw_pkg::ST_SLEEP || st_r == acsw_pkg::ST_IDLE) &&
                       st_nxt == acsw_pkg::ST_AWAKE;

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_r <= acsw_pkg::ST_SLEEP;
            wdog_r <= '0;
            tmo_r <= '0;
            exec_r <= '0;
        end else begin
            st_r <= st_nxt;
            // only sleep or idle clear the count, so a wake while awake cannot restart it
            wdog_r <= awake ? wdog_r + 32'd1 : '0; // [R1] [R3]
            tmo_r <= (st_r == acsw_pkg::ST_RX && !ev_byte) ? tmo_r + 32'd1 : '0;
            exec_r <= running_r ? exec_r + 32'd1 : '0;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            idx_r <= 8'h00;
            cnt_r <= 8'h00;
            op_r <= 8'h00;
            p1_r <= 8'h00;
            p2_r <= 16'h0000;
            crc_r <= `ACSW_CRC_INIT;
            crc_lo_r <= 8'h00;
            have_flag_r <= 1'b0;
        end else if (to_sleep || st_r != acsw_pkg::ST_RX) begin
            idx_r <= 8'h00;
            crc_r <= `ACSW_CRC_INIT;
            // the flag byte is what moves awake into receive, so it is counted here
            have_flag_r <= ev_byte & (st_r == acsw_pkg::ST_AWAKE) & ~to_sleep; // [R7]
            if (to_sleep) begin // [R4]
                cnt_r <= 8'h00;
                op_r <= 8'h00;
                p1_r <= 8'h00;
                p2_r <= 16'h0000;
                crc_lo_r <= 8'h00;
            end
        end else if (ev_byte) begin
            if (!have_flag_r) begin
                have_flag_r <= 1'b1; // [R7]
            end else begin
                idx_r <= idx_r + 8'h01;
                if (idx_r == `ACSW_POS_COUNT) cnt_r <= s_byte; // [R8]
                if (idx_r == `ACSW_POS_OPCODE) op_r <= s_byte; // [R9]
                if (idx_r == `ACSW_POS_P1) p1_r <= s_byte; // [R9]
                if (idx_r == `ACSW_POS_P2_LO) p2_r[7:0] <= s_byte; // [R9]
                if (idx_r == `ACSW_POS_P2_HI) p2_r[15:8] <= s_byte; // [R9]
                if (idx_r == `ACSW_POS_COUNT || !in_crc) begin
                    crc_r <= crc_byte(crc_r, s_byte); // [R10]
                end else if (!last_byte) begin
                    crc_lo_r <= s_byte;
                end
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            status_r <= `ACSW_ST_RESET;
            running_r <= 1'b0;
            start_r <= 1'b0;
            abort_r <= 1'b0;
            sram_clr_r <= 1'b0;
            dvld_r <= 1'b0;
            data_r <= 8'h00;
        end else begin
            start_r <= 1'b0;
            abort_r <= 1'b0;
            dvld_r <= 1'b0;
            sram_clr_r <= to_sleep; // [R4] idle never raises it [R5]
            if (to_sleep) begin
                status_r <= `ACSW_ST_RESET; // [R4]
                running_r <= 1'b0;
                abort_r <= running_r; // [R2]
            end else if (awake_entry) begin
                status_r <= `ACSW_ST_WAKE; // [R24]
            end else if (st_r == acsw_pkg::ST_RX && ev_stsp && !swi_mode) begin
                status_r <= `ACSW_ST_COMM; // [R14]
            end else if (decide) begin
                if (!crc_ok) status_r <= `ACSW_ST_COMM; // [R25]
                else if (parse_bad) status_r <= `ACSW_ST_PARSE; // [R28]
                else if (bad_extra) status_r <= `ACSW_ST_EXEC; // [R20]
                else start_r <= 1'b1; // [R11]
            end else if (start_r) begin
                running_r <= 1'b1;
            end else if (running_r && exec_done_i) begin
                running_r <= 1'b0;
                status_r <= exec_status_i;
            end else if (exec_exp) begin
                running_r <= 1'b0;
                abort_r <= 1'b1;
                status_r <= `ACSW_ST_EXEC; // [R22]
            end
            if (st_r == acsw_pkg::ST_RX && ev_byte && have_flag_r &&
                idx_r > `ACSW_POS_P2_HI && !in_crc) begin
                dvld_r <= 1'b1;
                data_r <= s_byte;
            end
        end
    end
    // busy covers decision cycle and execution so the link stays deaf throughout
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            busy_r <= 1'b0;
        end else begin
            busy_r <= (st_nxt == acsw_pkg::ST_BUSY); // [R12]
        end
    end

    assign awake_o = awake;
    assign busy_o = busy_r;
    assign idle_o = (st_r == acsw_pkg::ST_IDLE);
    assign sram_clear_o = sram_clr_r;
    assign status_o = status_r;
    assign cmd_start_o = start_r;
    assign exec_abort_o = abort_r;
    assign cmd_opcode_o = op_r;
    assign cmd_kind_o = kind;
    assign cmd_p1_o = p1_r;
    assign cmd_p2_o = p2_r;
    assign data_vld_o = dvld_r;
    assign data_o = data_r;

    property p_wake_status;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        (st_r == acsw_pkg::ST_SLEEP && ev_wake) |=> (status_r == `ACSW_ST_WAKE) && awake;
    endproperty
    a_wake_status: assert property (p_wake_status) else $error("no 0x11 after wake"); // [R24]
    property p_wdog_start;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        (st_r == acsw_pkg::ST_SLEEP && ev_wake) |=> (wdog_r == 32'd0) ##1 (wdog_r == 32'd1);
    endproperty
    a_wdog_start: assert property (p_wdog_start) else $error("watchdog not started"); // [R1]
    property p_wdog_exp;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        wdog_exp |=> (st_r == acsw_pkg::ST_SLEEP) && !busy_r;
    endproperty
    a_wdog_exp: assert property (p_wdog_exp) else $error("no sleep at expiry"); // [R2]
    property p_no_restart;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        awake && $past(awake) |-> wdog_r == $past(wdog_r) + 32'd1;
    endproperty
    a_no_restart: assert property (p_no_restart) else $error("watchdog restarted"); // [R3]
    property p_sleep_clear;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        (awake && st_nxt == acsw_pkg::ST_SLEEP) |=> sram_clear_o && status_r == `ACSW_ST_RESET;
    endproperty
    a_sleep_clear: assert property (p_sleep_clear) else $error("sleep did not clear"); // [R4]
    property p_idle_keep;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        (st_r == acsw_pkg::ST_AWAKE && st_nxt == acsw_pkg::ST_IDLE) |=> !sram_clear_o [*2];
    endproperty
    a_idle_keep: assert property (p_idle_keep) else $error("idle cleared SRAM"); // [R5]
    property p_busy_after_last;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        (last_byte && !wdog_exp) |=> busy_r && st_r == acsw_pkg::ST_BUSY;
    endproperty
    a_busy_after_last: assert property (p_busy_after_last) else $error("not busy"); // [R11]
    property p_link_deaf;
        @(posedge link_clk_i) disable iff (!rstn_i)
        l_busy |=> ltog_r == $past(ltog_r);
    endproperty
    a_link_deaf: assert property (p_link_deaf) else $error("link heard while busy"); // [R12]
    property p_crc_fail;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        (decide && !crc_ok) |=> status_r == `ACSW_ST_COMM && !start_r ##1 !running_r;
    endproperty
    a_crc_fail: assert property (p_crc_fail) else $error("bad CRC executed"); // [R25]
    property p_unknown_op;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        (decide && crc_ok && kind == acsw_pkg::K_NONE) |=> status_r == `ACSW_ST_PARSE;
    endproperty
    a_unknown_op: assert property (p_unknown_op) else $error("unknown opcode ran"); // [R28]
    property p_swi_timeout;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        tmo_exp |=> st_r == acsw_pkg::ST_SLEEP;
    endproperty
    a_swi_timeout: assert property (p_swi_timeout) else $error("no timeout sleep"); // [R13]
    property p_i2c_wait;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        (st_r == acsw_pkg::ST_RX && !swi_mode && ev_stsp && !wdog_exp) |=>
            st_r == acsw_pkg::ST_AWAKE && status_r == `ACSW_ST_COMM;
    endproperty
    a_i2c_wait: assert property (p_i2c_wait) else $error("start/stop ignored"); // [R14]
    c_cmd_run: cover property (@(posedge clk_sys_i) disable iff (!rstn_i)
        start_r ##[1:50] (running_r && exec_done_i));
    c_idle_wake: cover property (@(posedge clk_sys_i) disable iff (!rstn_i)
        idle_o ##[1:200] awake_entry);
    c_wdog: cover property (@(posedge clk_sys_i) disable iff (!rstn_i) wdog_exp);
endmodule : acsw_top

// ---- verilog/acsw_defs.svh ----
// Purpose: shared constants of the command sequencer and watchdog
// Assumes: included by its bare name
// Notes: timing figures are in their own units, the execution cycle count derives from them
`ifndef ACSW_DEFS_SVH
`define ACSW_DEFS_SVH
`define ACSW_CLK_KHZ 10000
`define ACSW_EXEC_MAX_MS 69
`define ACSW_EXEC_MAX_CYC (`ACSW_EXEC_MAX_MS * `ACSW_CLK_KHZ)
`define ACSW_FAILSAFE_CYC 20000
`define ACSW_TIMEOUT_CYC 2000
`define ACSW_POS_COUNT 8'h00
`define ACSW_POS_OPCODE 8'h01
`define ACSW_POS_P1 8'h02
`define ACSW_POS_P2_LO 8'h03
`define ACSW_POS_P2_HI 8'h04
`define ACSW_MIN_COUNT 8'h07
`define ACSW_CRC_POLY 16'h8005
`define ACSW_CRC_INIT 16'h0000
`define ACSW_ST_OK 8'h00
`define ACSW_ST_PARSE 8'h03
`define ACSW_ST_EXEC 8'h0F
`define ACSW_ST_WAKE 8'h11
`define ACSW_ST_COMM 8'hFF
`define ACSW_ST_RESET 8'h00
`define ACSW_OP_KEYDER 8'h1C
`define ACSW_OP_REV 8'h30
`define ACSW_OP_DIGEST 8'h15
`define ACSW_OP_HMAC 8'h11
`define ACSW_OP_CHKMAC 8'h28
`define ACSW_OP_LOCK 8'h17
`define ACSW_OP_MAC 8'h08
`define ACSW_OP_NONCE 8'h16
`define ACSW_OP_PAUSE 8'h01
`define ACSW_OP_RAND 8'h1B
`define ACSW_OP_READ 8'h02
`define ACSW_OP_SHA 8'h47
`define ACSW_OP_EXTRA 8'h20
`define ACSW_OP_WRITE 8'h12
`define ACSW_EXTRA_LO 8'h54
`define ACSW_EXTRA_HI 8'h55
`define ACSW_WR_SHORT 8'h04
`define ACSW_WR_LONG 8'h20
`define ACSW_EV_WAKE 0
`define ACSW_EV_STSP 1
`define ACSW_EV_IDLE 2
`define ACSW_EV_SLEEP 3
`define ACSW_EV_BYTE 4
`define ACSW_EV_N 5
`endif

// ---- verilog/acsw_pkg.sv ----
// Purpose: types of the command sequencer and watchdog
// Assumes: nothing
// Notes: enums carry no codes
package acsw_pkg;
    typedef enum logic [2:0] {
        ST_SLEEP, ST_AWAKE, ST_RX, ST_BUSY, ST_IDLE
    } acsw_state_t;
    typedef enum logic [3:0] {
        K_NONE, K_KEYDER, K_REV, K_DIGEST, K_HMAC, K_CHKMAC, K_LOCK, K_MAC,
        K_NONCE, K_PAUSE, K_RAND, K_READ, K_SHA, K_EXTRA, K_WRITE
    } acsw_kind_t;
endpackage : acsw_pkg

// ---- verification/acsw_host_model.sv ----
// Purpose: host side of the link, sends events and command packets
// Assumes: link clock runs free; a released byte bus shows the inverse value
// Notes: strobes are 32 link clocks (480 ns) apart, above the 400 ns minimum
`timescale 1ns/1ps
`include "acsw_defs.svh"
module acsw_host_model #(
    parameter logic [7:0] FLAG = 8'h03
) (
    input wire logic link_clk_i,
    output logic byte_vld_o,
    output logic [7:0] byte_o,
    output logic wake_o,
    output logic stsp_o,
    output logic idle_o,
    output logic sleep_o
);
    logic [4:0] stb = 5'h00;
    initial byte_o = 8'h00;
    assign wake_o = stb[`ACSW_EV_WAKE];
    assign stsp_o = stb[`ACSW_EV_STSP];
    assign idle_o = stb[`ACSW_EV_IDLE];
    assign sleep_o = stb[`ACSW_EV_SLEEP];
    assign byte_vld_o = stb[`ACSW_EV_BYTE];

    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
        for (int i = 7; i >= 0; i--) begin
            c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? 16'h8005 : 16'h0000);
        end
        return c;
    endfunction : crc_step

    // one strobe; the host keeps the spacing and releases the bus after one clock
    task automatic ev(input int k, input logic [7:0] b);
        @(posedge link_clk_i);
        stb <= 5'(1 << k);
        byte_o <= b;
        @(posedge link_clk_i);
        stb <= 5'h00;
        byte_o <= ~b;
        repeat (30) @(posedge link_clk_i);
    endtask : ev

    task automatic send_pkt(input logic [7:0] op, input logic [7:0] p2, input int nd,
                            input bit bad);
        logic [7:0] b [$];
        logic [15:0] c;
        c = 16'h0000;
        b = '{8'(7 + nd), op, 8'h00, p2, 8'h00};
        for (int i = 0; i < nd; i++) b.push_back(8'(i));
        foreach (b[i]) c = crc_step(c, b[i]); // flag left out
        if (bad) c = ~c;
        ev(`ACSW_EV_BYTE, FLAG);
        foreach (b[i]) ev(`ACSW_EV_BYTE, b[i]);
        ev(`ACSW_EV_BYTE, c[7:0]);
        ev(`ACSW_EV_BYTE, c[15:8]);
    endtask : send_pkt
endmodule : acsw_host_model

// ---- verification/acsw_top_bench.sv ----
// Purpose: self-checking bench of the command sequencer and watchdog
// Assumes: short failsafe, timeout and execution counts
// Notes: execution engine is played by the bench through exec_done_i
`timescale 1ns/1ps
module acsw_top_bench;
    localparam int FS = 3000;
    localparam int TO = 50;
    localparam int EM = 100;
    logic clk_sys_i = 1'b0;
    logic link_clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic single_wire_i = 1'b0;
    logic config_locked_i = 1'b1;
    logic exec_done_i = 1'b0;
    logic [7:0] exec_status_i = 8'h00;
    logic vld, wk, ss, idl, slp, link_busy_o, awake_o, busy_o, idle_o, sram_clear_o;
    logic cmd_start_o, abort_o, dvld_o;
    logic [7:0] opcode_o, op_seen;
    logic [15:0] p2_o, p2_seen;
    int aborts = 0, dbytes = 0;
    logic [7:0] lbyte, status_o;
    acsw_pkg::acsw_kind_t cmd_kind_o, kind_seen;
    int failures = 0, checks_done = 0, starts = 0, clears = 0, cyc = 0;
    logic [7:0] ops [14] = '{8'h1C, 8'h30, 8'h15, 8'h11, 8'h28, 8'h17, 8'h08, 8'h16,
                             8'h1B, 8'h02, 8'h47, 8'h20, 8'h12, 8'h01};
    acsw_pkg::acsw_kind_t kinds [14] = '{acsw_pkg::K_KEYDER, acsw_pkg::K_REV,
        acsw_pkg::K_DIGEST, acsw_pkg::K_HMAC, acsw_pkg::K_CHKMAC, acsw_pkg::K_LOCK,
        acsw_pkg::K_MAC, acsw_pkg::K_NONCE, acsw_pkg::K_RAND, acsw_pkg::K_READ,
        acsw_pkg::K_SHA, acsw_pkg::K_EXTRA, acsw_pkg::K_WRITE, acsw_pkg::K_PAUSE};

    always #50 clk_sys_i = ~clk_sys_i;
    always #7.5 link_clk_i = ~link_clk_i;

    acsw_top #(.FAILSAFE_CYCLES(FS), .TIMEOUT_CYCLES(TO), .EXEC_MAX_CYCLES(EM)) u_acsw_top (
        .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .link_clk_i(link_clk_i),
        .link_byte_vld_i(vld), .link_byte_i(lbyte), .link_wake_i(wk), .link_stsp_i(ss),
        .link_idle_i(idl), .link_sleep_i(slp), .single_wire_i(single_wire_i),
        .config_locked_i(config_locked_i), .exec_done_i(exec_done_i),
        .exec_status_i(exec_status_i), .link_busy_o(link_busy_o), .awake_o(awake_o),
        .busy_o(busy_o), .idle_o(idle_o), .sram_clear_o(sram_clear_o),
        .status_o(status_o), .cmd_start_o(cmd_start_o), .exec_abort_o(abort_o),
        .cmd_opcode_o(opcode_o), .cmd_kind_o(cmd_kind_o), .cmd_p1_o(), .cmd_p2_o(p2_o),
        .data_vld_o(dvld_o), .data_o());
    acsw_host_model u_acsw_host_model (.link_clk_i(link_clk_i), .byte_vld_o(vld),
        .byte_o(lbyte), .wake_o(wk), .stsp_o(ss), .idle_o(idl), .sleep_o(slp));

    always @(posedge clk_sys_i) begin
        cyc++;
        if (cmd_start_o === 1'b1) begin
            starts++;
            kind_seen = cmd_kind_o;
            op_seen = opcode_o;
            p2_seen = p2_o;
        end
        if (abort_o === 1'b1) aborts++;
        if (dvld_o === 1'b1) dbytes++;
        if (sram_clear_o === 1'b1) clears++;
        if (cyc == 20000) begin
            failures++;
            end_sim();
        end
    end

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
        checks_done++;
        if (s !== e) begin
            $display("ERROR %s expected %h seen %h", n, e, s);
            failures++;
        end
    endtask : chk

    task automatic clks(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask : clks

    task automatic ev(input int k);
        u_acsw_host_model.ev(k, 8'h00);
        clks(2);
    endtask : ev

    task automatic finish_cmd();
        exec_done_i <= 1'b1;
        exec_status_i <= 8'h01;
        clks(1);
        exec_done_i <= 1'b0;
        clks(3);
    endtask : finish_cmd

    task automatic run(input logic [7:0] op, input int nd, input bit bad, input bit es,
                       input acsw_pkg::acsw_kind_t k, input logic [7:0] st);
        int s0;
        s0 = starts;
        u_acsw_host_model.send_pkt(op, 8'h54, nd, bad);
        clks(6);
        for (int i = 0; i < 40 && starts == s0 && busy_o !== 1'b0; i++) clks(1);
        clks(2);
        chk("start", 16'(es), 16'(starts != s0));
        if (starts != s0) begin
            chk("kind", 16'(k), 16'(kind_seen));
            chk("opcode", 16'(op), 16'(op_seen));
            chk("p2", 16'h0054, p2_seen);
            finish_cmd();
        end
        chk("status", 16'(st), 16'(status_o));
        chk("busy", 16'h0000, 16'(busy_o));
    endtask : run

    task automatic end_sim();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_sim

    initial begin
        int c0;
        clks(20);
        rstn_i <= 1'b1;
        clks(3);
        ev(0);
        chk("awake", 16'h0001, 16'(awake_o));
        chk("status", 16'h0011, 16'(status_o));
        for (int i = 0; i < 14; i++) begin
            run(ops[i], (ops[i] == 8'h12) ? 4 : 0, 0, 1, kinds[i], 8'h01);
        end
        chk("data", 16'h0004, 16'(dbytes));
        ev(0);
        chk("awake", 16'h0001, 16'(awake_o));
        run(8'h30, 0, 1, 0, acsw_pkg::K_NONE, 8'hFF);
        run(8'h99, 0, 0, 0, acsw_pkg::K_NONE, 8'h03);
        run(8'h12, 3, 0, 0, acsw_pkg::K_NONE, 8'h03);
        config_locked_i <= 1'b0;
        run(8'h20, 0, 0, 0, acsw_pkg::K_NONE, 8'h0F);
        config_locked_i <= 1'b1;
        c0 = clears;
        u_acsw_host_model.send_pkt(8'h30, 8'h00, 0, 0);
        clks(6);
        chk("link_busy", 16'h0001, 16'(link_busy_o));
        ev(3);
        chk("awake", 16'h0001, 16'(awake_o));
        clks(EM + 10);
        chk("status", 16'h000F, 16'(status_o));
        chk("abort", 16'h0001, 16'(aborts));
        ev(2);
        chk("idle", 16'h0001, 16'(idle_o));
        ev(0);
        chk("clears", 16'(c0), 16'(clears));
        clks(FS - 100);
        chk("awake", 16'h0001, 16'(awake_o));
        clks(200);
        chk("awake", 16'h0000, 16'(awake_o));
        chk("clears", 16'(c0 + 1), 16'(clears));
        single_wire_i <= 1'b1;
        ev(0);
        repeat (3) u_acsw_host_model.ev(4, 8'h07);
        clks(TO + 20);
        chk("awake", 16'h0000, 16'(awake_o));
        single_wire_i <= 1'b0;
        ev(0);
        repeat (3) u_acsw_host_model.ev(4, 8'h07);
        clks(TO + 20);
        chk("awake", 16'h0001, 16'(awake_o));
        ev(1);
        chk("status", 16'h00FF, 16'(status_o));
        end_sim();
    end
endmodule : acsw_top_bench
